// ---- include/rsca_map.svh ----
`ifndef RSCA_MAP_SVH
`define RSCA_MAP_SVH

// Configuration word size and value after reset.
`define RSCA_CFG_W 20
`define RSCA_CFG_RESET 20'h42E78

// Core clock rate in MHz.
`define RSCA_CLK_MHZ 50

// Slowest legal serial clock in kHz; beyond one period of it the interface gives up.
`define RSCA_MIN_SCLK_KHZ 5
`define RSCA_TIMEOUT_CYC (`RSCA_CLK_MHZ * 1000 / `RSCA_MIN_SCLK_KHZ)

// Shortest sleep period in ms; each sleep code step doubles it.
`define RSCA_SLEEP_BASE_MS 10
`define RSCA_SLEEP_BASE_CYC (`RSCA_SLEEP_BASE_MS * 1000 * `RSCA_CLK_MHZ)

// Squelch pulse repeat period in ms and pulse width in us.
`define RSCA_SQ_PERIOD_MS 100
`define RSCA_SQ_PERIOD_CYC (`RSCA_SQ_PERIOD_MS * 1000 * `RSCA_CLK_MHZ)
`define RSCA_SQ_PULSE_US 1000
`define RSCA_SQ_PULSE_CYC (`RSCA_SQ_PULSE_US * `RSCA_CLK_MHZ)

// Consecutive bad bits that end a polling period.
`define RSCA_BAD_LIMIT 3'h4

// Bit-check window in us at the narrowest bandwidth, one per window code.
`define RSCA_WIN0_US 570
`define RSCA_WIN1_US 532
`define RSCA_WIN2_US 494
`define RSCA_WIN3_US 457
`define RSCA_WIN4_US 419
`define RSCA_WIN5_US 381
`define RSCA_WIN6_US 343
`define RSCA_WIN7_US 305

// Width of the serial bit counter that crosses between the clocks.
`define RSCA_PTR_W 6

`endif

// ---- include/rsca_pkg.sv ----
package rsca_pkg;

  // Receiver configuration word, most significant field first.
  typedef struct packed {
    logic must_zero;
    logic must_one;
    logic squelch_sel;
    logic spare;
    logic autopoll;
    logic [2:0] sleep_code;
    logic [2:0] window_code;
    logic [1:0] valid_code;
    logic [1:0] slice;
    logic [1:0] bandwidth;
    logic [1:0] desense_sel;
    logic desense_en;
  } rsca_cfg_type;

  // Serial programming sequence states.
  typedef enum logic [7:0] {
    SER_IDLE = 8'h01,
    SER_REL = 8'h02,
    SER_ARM_LO = 8'h04,
    SER_ARM_HI = 8'h08,
    SER_START = 8'h10,
    SER_PROG = 8'h20,
    SER_STOP_HI = 8'h40,
    SER_STOP_END = 8'h80
  } rsca_ser_type;

  // Receive power states.
  typedef enum logic [2:0] {
    POLL_AWAKE = 3'h1,
    POLL_SLEEP = 3'h2,
    POLL_CHECK = 3'h4
  } rsca_poll_type;

endpackage

// ---- core/rsca_sync.sv ----
`timescale 1ns/100ps
`include "rsca_map.svh"

module rsca_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Foreign input and settled value.
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held;
  logic [W-1:0] next_held;

  // A change counts only once stages two and three agree, which also filters one-cycle glitches.
  always_comb begin
    next_held = (s2 == s3) ? s3 : held;
  end

  assign o_q = next_held;

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
    end
  end

endmodule // rsca_sync

// ---- core/rsca_link_shift.sv ----
`timescale 1ns/100ps
`include "rsca_map.svh"

module rsca_link_shift (
  // Serial clock and reset.
  input wire logic i_sclk,
  input wire logic i_nrst,
  // Data pin as seen by the device.
  input wire logic i_data,
  // Last bits shifted and gray-coded count of rising edges.
  output logic [`RSCA_CFG_W-1:0] o_word,
  output logic [`RSCA_PTR_W-1:0] o_ptr_gray
);

  logic [`RSCA_PTR_W-1:0] cnt;
  logic [`RSCA_PTR_W-1:0] next_cnt;
  logic [`RSCA_CFG_W-1:0] next_word;
  logic [`RSCA_PTR_W-1:0] next_gray;

  // Each rising edge shifts one bit in at the bottom, so the last bit sent lands in bit 0.
  always_comb begin
    next_word = {o_word[`RSCA_CFG_W-2:0], i_data};
    next_cnt = cnt + `RSCA_PTR_W'(1);
    next_gray = next_cnt ^ (next_cnt >> 1);
  end

  // The count crosses in gray code so a sample mid-change is off by one at worst.
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word <= '0;
      cnt <= '0;
      o_ptr_gray <= '0;
    end else begin
      o_word <= next_word;
      cnt <= next_cnt;
      o_ptr_gray <= next_gray;
    end
  end

endmodule // rsca_link_shift

// ---- core/rsca_rx_ctrl.sv ----
`timescale 1ns/100ps
`include "rsca_map.svh"

// Notes on behaviour
// - Auto-poll bit set holds the data pin low while looking for signal.
// - Auto-poll alternates a sleep state and a polling state with bit checking.
// - Sleep code picks 10ms doubled per step up to 1280ms; default 40ms.
// - A mark or space longer than the window is valid, shorter is bad.
// - Window code picks eight windows, shrinking with code, scaled by bandwidth.
// - Valid-bit code asks for 0, 4, 8 or 16 valid bits in a row.
// - Four bad bits in a row while polling send the device back to sleep.
// - Enough valid bits release the data pin into continuous receive.
// - Continuous receive lasts until the host writes the configuration again.
// - Squelch is active when the strap pin equals squelch select bit.
// - Active squelch without signal pulses the data pin about every 100ms.
// - Slice code picks 30, 40, 50 or 60 percent threshold.
// - Desense enable with two select bits fixes gain and stops the gain loop.
// - Serial clock high releases the data pin; the host then drives it.
// - A serial clock slower than 5kHz resets the interface; the code resets only when one clock level lasts past a 5kHz period.
// - Bits arrive most significant first down to bit 0; partial writes allowed.
// - Stop is data low, high, low under high clock, then clock low.
// - The pin turns to input within 0.1us of the clock rising.
// - The bit checker watches the sliced signal before output gating.
module rsca_rx_ctrl
  import rsca_pkg::*;
#(
  parameter int TIMEOUT_CYC = `RSCA_TIMEOUT_CYC,
  parameter int SLEEP_BASE_CYC = `RSCA_SLEEP_BASE_CYC,
  parameter int SQ_PERIOD_CYC = `RSCA_SQ_PERIOD_CYC,
  parameter int SQ_PULSE_CYC = `RSCA_SQ_PULSE_CYC
) (
  // Core clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Serial link: clock pin and the two-way data pin.
  input wire logic I_SCLK,
  input wire logic I_DO_IN,
  output logic O_DO_OUT,
  output logic O_DO_OE,
  // Analog front end: sliced demodulator output and squelch strap.
  input wire logic I_DEMOD,
  input wire logic I_SQUELCH_STRAP_PIN,
  // Settings driven into the analog blocks.
  output logic [1:0] O_SLICE_LEVEL,
  output logic [1:0] O_DEMOD_BW,
  output logic O_DESENSE_EN,
  output logic [1:0] O_DESENSE_SEL,
  output logic O_SQUELCH_ACTIVE,
  output logic O_SLEEP
);

  localparam int PW = `RSCA_PTR_W;

  // Pin and link signals brought into the core domain.
  logic sclk_s;
  logic data_s;
  logic demod_s;
  logic strap_s;
  logic [`RSCA_CFG_W-1:0] link_word;
  logic [PW-1:0] link_gray;
  logic [`RSCA_CFG_W-1:0] word_s;
  logic [PW-1:0] gray_s;
  logic [PW-1:0] ptr_s;

  // Serial sequence state.
  rsca_ser_type ser_state;
  rsca_ser_type next_ser_state;
  logic [15:0] to_cnt;
  logic [15:0] next_to_cnt;
  logic sclk_prev;
  logic [PW-1:0] start_ptr;
  logic [PW-1:0] next_start_ptr;
  rsca_cfg_type cfg;
  rsca_cfg_type next_cfg;
  logic commit;
  logic next_commit;

  // Receive state.
  rsca_poll_type poll_state;
  rsca_poll_type next_poll_state;
  logic [25:0] sleep_cnt;
  logic [25:0] next_sleep_cnt;
  logic [15:0] run_cnt;
  logic [15:0] next_run_cnt;
  logic demod_prev;
  logic [4:0] valid_cnt;
  logic [4:0] next_valid_cnt;
  logic [2:0] bad_cnt;
  logic [2:0] next_bad_cnt;
  logic sq_open;
  logic next_sq_open;
  logic [22:0] sq_cnt;
  logic [22:0] next_sq_cnt;
  logic next_do_out;
  logic next_do_oe;
  logic next_squelch;
  logic [1:0] settle;
  logic [1:0] next_settle;

  // Link-side capture runs on the serial clock itself.
  rsca_link_shift u_link (
    .i_sclk(I_SCLK),
    .i_nrst(I_NRST),
    .i_data(I_DO_IN),
    .o_word(link_word),
    .o_ptr_gray(link_gray)
  );

  // Asynchronous pins pass the three-stage agreement filter.
  rsca_sync #(.W(4)) u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .i_d({I_SCLK, I_DO_IN, I_DEMOD, I_SQUELCH_STRAP_PIN}),
    .o_q({sclk_s, data_s, demod_s, strap_s})
  );

  // The shifted word is static while the clock rests high at stop, so a plain sync is safe.
  rsca_sync #(.W(`RSCA_CFG_W + PW)) u_link_sync (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .i_d({link_word, link_gray}),
    .o_q({word_s, gray_s})
  );

  // Gray to binary for the edge count.
  always_comb begin
    ptr_s[PW-1] = gray_s[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      ptr_s[i] = ptr_s[i+1] ^ gray_s[i];
    end
  end

  // Bit-check window in core cycles for the current codes.
  function automatic logic [15:0] win_cycles(input logic [2:0] code, input logic [1:0] bw);
    int us;
    us = `RSCA_WIN0_US;
    unique case (code)
      3'h0: us = `RSCA_WIN0_US;
      3'h1: us = `RSCA_WIN1_US;
      3'h2: us = `RSCA_WIN2_US;
      3'h3: us = `RSCA_WIN3_US;
      3'h4: us = `RSCA_WIN4_US;
      3'h5: us = `RSCA_WIN5_US;
      3'h6: us = `RSCA_WIN6_US;
      3'h7: us = `RSCA_WIN7_US;
    endcase
    return 16'((us * `RSCA_CLK_MHZ) >> bw);
  endfunction

  // Serial sequence: start detect, bit window, stop detect and commit.
  always_comb begin
    logic [PW-1:0] nbits;
    logic [`RSCA_CFG_W-1:0] mask;
    nbits = ptr_s - start_ptr;
    mask = '1;
    next_ser_state = ser_state;
    next_start_ptr = start_ptr;
    next_cfg = cfg;
    next_commit = 1'b0;
    // Any clock edge restarts the watchdog; a stalled clock drops the sequence.
    next_to_cnt = (sclk_s != sclk_prev || ser_state == SER_IDLE) ? 16'h0000 : to_cnt + 16'h0001;
    if (ser_state != SER_IDLE && int'(to_cnt) >= TIMEOUT_CYC) begin
      next_ser_state = SER_IDLE;
    end else begin
      unique case (ser_state)
        SER_IDLE: if (sclk_s && !sclk_prev) next_ser_state = SER_REL;
        SER_REL: if (!sclk_s) next_ser_state = SER_ARM_LO;
        SER_ARM_LO: if (sclk_s && !data_s) next_ser_state = SER_ARM_HI;
        SER_ARM_HI: begin
          if (!sclk_s) next_ser_state = SER_ARM_LO;
          else if (data_s) next_ser_state = SER_START;
        end
        SER_START: begin
          if (!sclk_s) begin
            next_ser_state = SER_ARM_LO;
          end else if (!data_s) begin
            next_ser_state = SER_PROG;
            next_start_ptr = ptr_s;
          end
        end
        SER_PROG: if (sclk_s && !sclk_prev) begin
          // Data only moves under a high clock during stop; a fresh high clock starts a bit.
          next_ser_state = SER_PROG;
        end else if (sclk_s && data_s) begin
          next_ser_state = SER_STOP_HI;
        end
        SER_STOP_HI: begin
          if (!sclk_s) next_ser_state = SER_PROG;
          else if (!data_s) next_ser_state = SER_STOP_END;
        end
        SER_STOP_END: begin
          if (data_s) begin
            next_ser_state = SER_STOP_HI;
          end else if (!sclk_s) begin
            // Only the bits shifted since start replace the low end of the word.
            if (int'(nbits) < `RSCA_CFG_W) mask = (`RSCA_CFG_W'(1) << nbits) - `RSCA_CFG_W'(1);
            next_cfg = (cfg & ~mask) | (word_s & mask);
            next_commit = 1'b1;
            next_ser_state = SER_IDLE;
          end
        end
      endcase
    end
  end

  // Serial sequence registers.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ser_state <= SER_IDLE;
      to_cnt <= 16'h0000;
      sclk_prev <= 1'b0;
      start_ptr <= '0;
      cfg <= `RSCA_CFG_RESET;
      commit <= 1'b0;
    end else begin
      ser_state <= next_ser_state;
      to_cnt <= next_to_cnt;
      sclk_prev <= sclk_s;
      start_ptr <= next_start_ptr;
      cfg <= next_cfg;
      commit <= next_commit;
    end
  end

  // Receive control: sleep, bit checking, continuous receive and squelch gating.
  always_comb begin
    logic bit_end;
    logic is_valid;
    logic [4:0] need;
    bit_end = (demod_s != demod_prev);
    is_valid = run_cnt > win_cycles(cfg.window_code, cfg.bandwidth);
    need = (cfg.valid_code == 2'h0) ? 5'h00 : 5'(5'h02 << cfg.valid_code);
    next_poll_state = poll_state;
    next_sleep_cnt = sleep_cnt;
    next_run_cnt = bit_end ? 16'h0000 : ((run_cnt == 16'hFFFF) ? run_cnt : run_cnt + 16'h0001);
    next_valid_cnt = valid_cnt;
    next_bad_cnt = bad_cnt;
    next_sq_open = sq_open;
    next_sq_cnt = (int'(sq_cnt) >= SQ_PERIOD_CYC - 1) ? 23'h000000 : sq_cnt + 23'h000001;
    if (bit_end) begin
      next_valid_cnt = is_valid ? ((valid_cnt == 5'h1F) ? valid_cnt : valid_cnt + 5'h01) : 5'h00;
      next_bad_cnt = is_valid ? 3'h0 : ((bad_cnt == 3'h7) ? bad_cnt : bad_cnt + 3'h1);
    end
    if (commit) begin
      // A new write is the only way out of continuous receive.
      next_poll_state = cfg.autopoll ? POLL_SLEEP : POLL_AWAKE;
      next_sleep_cnt = 26'h0000000;
      next_sq_open = 1'b0;
    end else begin
      unique case (poll_state)
        POLL_SLEEP: begin
          next_sleep_cnt = sleep_cnt + 26'h0000001;
          if (int'(sleep_cnt) >= (SLEEP_BASE_CYC << cfg.sleep_code) - 1) begin
            next_poll_state = POLL_CHECK;
            next_run_cnt = 16'h0000;
            next_valid_cnt = 5'h00;
            next_bad_cnt = 3'h0;
          end
        end
        POLL_CHECK: begin
          if (next_valid_cnt >= need) begin
            next_poll_state = POLL_AWAKE;
          end else if (next_bad_cnt >= `RSCA_BAD_LIMIT) begin
            next_poll_state = POLL_SLEEP;
            next_sleep_cnt = 26'h0000000;
          end
        end
        POLL_AWAKE: begin
          // Squelch opens after four valid bits and closes after four bad ones.
          if (next_valid_cnt >= 5'h04) next_sq_open = 1'b1;
          else if (next_bad_cnt >= `RSCA_BAD_LIMIT) next_sq_open = 1'b0;
        end
      endcase
    end
    // The strap sync resets low, so squelch waits until the chain has filled.
    next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
    next_squelch = (settle == 2'h3) && (strap_s == cfg.squelch_sel);
    // The pin shows data only when awake; squelch swaps chatter for a slow pulse.
    if (next_poll_state != POLL_AWAKE) next_do_out = 1'b0;
    else if (O_SQUELCH_ACTIVE && !sq_open) next_do_out = int'(sq_cnt) < SQ_PULSE_CYC;
    else next_do_out = demod_s;
    // A high serial clock or any open sequence keeps the pin released.
    next_do_oe = (next_ser_state == SER_IDLE) && !sclk_s;
  end

  // Receive registers and pin drivers.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      poll_state <= POLL_AWAKE;
      sleep_cnt <= 26'h0000000;
      run_cnt <= 16'h0000;
      demod_prev <= 1'b0;
      valid_cnt <= 5'h00;
      bad_cnt <= 3'h0;
      sq_open <= 1'b0;
      sq_cnt <= 23'h000000;
      O_DO_OUT <= 1'b0;
      O_DO_OE <= 1'b1;
      O_SQUELCH_ACTIVE <= 1'b0;
      O_SLEEP <= 1'b0;
      settle <= 2'h0;
    end else begin
      poll_state <= next_poll_state;
      sleep_cnt <= next_sleep_cnt;
      run_cnt <= next_run_cnt;
      demod_prev <= demod_s;
      valid_cnt <= next_valid_cnt;
      bad_cnt <= next_bad_cnt;
      sq_open <= next_sq_open;
      sq_cnt <= next_sq_cnt;
      O_DO_OUT <= next_do_out;
      O_DO_OE <= next_do_oe;
      O_SQUELCH_ACTIVE <= next_squelch;
      O_SLEEP <= (next_poll_state == POLL_SLEEP);
      settle <= next_settle;
    end
  end

  // Analog settings come straight from the configuration flops.
  assign O_SLICE_LEVEL = cfg.slice;
  assign O_DEMOD_BW = cfg.bandwidth;
  assign O_DESENSE_EN = cfg.desense_en;
  assign O_DESENSE_SEL = cfg.desense_sel;

endmodule // rsca_rx_ctrl

// ---- sim/rsca_rx_ctrl_asserts.sv ----
`timescale 1ns/100ps

module rsca_rx_ctrl_asserts #(
  parameter int SLEEP_BASE_CYC = 100
) (
  // Clock, reset and watched pins.
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_SCLK,
  input wire logic I_SQUELCH_STRAP_PIN,
  input wire logic O_DO_OUT,
  input wire logic O_DO_OE,
  input wire logic [1:0] O_SLICE_LEVEL,
  input wire logic [1:0] O_DEMOD_BW,
  input wire logic O_DESENSE_EN,
  input wire logic [1:0] O_DESENSE_SEL,
  input wire logic O_SQUELCH_ACTIVE,
  input wire logic O_SLEEP
);
  logic [6:0] cfg;
  int sleep_cnt;
  int next_sleep_cnt;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  // Settings toward the analog blocks, watched as one word.
  assign cfg = {O_SLICE_LEVEL, O_DEMOD_BW, O_DESENSE_EN, O_DESENSE_SEL};

  // Sleep length counter; a stuck sleep timer would let it run past the longest code.
  always_comb begin
    next_sleep_cnt = O_SLEEP ? sleep_cnt + 1 : 0;
  end
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sleep_cnt <= 0;
    end else begin
      sleep_cnt <= next_sleep_cnt;
    end
  end

  property p_oe_release;
    $rose(I_SCLK) |-> ##[1:6] !O_DO_OE;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("pin kept after clock rise");
  property p_oe_hold;
    (!O_DO_OE && I_SCLK) |=> !O_DO_OE;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin driven under high clock");
  property p_cfg_hold;
    (!O_DO_OE && I_SCLK) |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid frame");
  property p_cfg_commit;
    $changed(cfg) |=> O_DO_OE;
  endproperty
  a_cfg_commit: assert property (p_cfg_commit) else $error("pin not driven after commit");
  property p_sleep_low;
    O_SLEEP |-> !O_DO_OUT;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("data high while asleep");
  property p_sleep_min;
    $rose(O_SLEEP) |-> O_SLEEP [*8];
  endproperty
  a_sleep_min: assert property (p_sleep_min) else $error("sleep too short");
  property p_sleep_max;
    sleep_cnt <= SLEEP_BASE_CYC * 128 + 2;
  endproperty
  a_sleep_max: assert property (p_sleep_max) else $error("sleep too long");
  property p_squelch;
    ($changed(I_SQUELCH_STRAP_PIN) && O_DO_OE) |-> ##[2:6] $changed(O_SQUELCH_ACTIVE);
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch ignores strap");

  // Main scenarios reached.
  c_release: cover property ($fell(O_DO_OE));
  c_sleep: cover property ($rose(O_SLEEP));
  c_wake: cover property ($fell(O_SLEEP));
  c_squelch: cover property ($rose(O_SQUELCH_ACTIVE));
endmodule // rsca_rx_ctrl_asserts

bind rsca_rx_ctrl rsca_rx_ctrl_asserts #(.SLEEP_BASE_CYC(SLEEP_BASE_CYC)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_SCLK(I_SCLK),
  .I_SQUELCH_STRAP_PIN(I_SQUELCH_STRAP_PIN), .O_DO_OUT(O_DO_OUT), .O_DO_OE(O_DO_OE),
  .O_SLICE_LEVEL(O_SLICE_LEVEL), .O_DEMOD_BW(O_DEMOD_BW), .O_DESENSE_EN(O_DESENSE_EN),
  .O_DESENSE_SEL(O_DESENSE_SEL), .O_SQUELCH_ACTIVE(O_SQUELCH_ACTIVE), .O_SLEEP(O_SLEEP));

// ---- sim/rsca_host.sv ----
`timescale 1ns/100ps

module rsca_host (
  // Pins driven toward the device.
  output logic o_sclk,
  output logic o_data,
  output logic o_oe
);
  int step = 120;

  // Idle with clock low and the data line left to the device.
  initial begin
    o_sclk = 1'b0;
    o_data = 1'b0;
    o_oe = 1'b0;
  end

  // The data line is taken only a step after the clock rises, once the device let go.
  task automatic start();
    o_sclk = 1'b1;
    #(step) o_oe = 1'b1;
    o_data = 1'b0;
    #(step) o_sclk = 1'b0;
    #(step) o_sclk = 1'b1;
    #(step) o_data = 1'b1;
    #(step) o_data = 1'b0;
    #(step);
  endtask

  // Bits go most significant first; data changes only while the clock is low.
  task automatic shift(input int n, input logic [19:0] w);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      #(step) o_data = w[i];
      #(step) o_sclk = 1'b1;
      #(step);
    end
  endtask

  // Stop pulse under high clock, then the line is handed back.
  task automatic finish();
    o_data = 1'b0;
    #(step) o_data = 1'b1;
    #(step) o_data = 1'b0;
    #(step) o_sclk = 1'b0;
    #(step) o_oe = 1'b0;
  endtask

  // One complete write of the low n bits.
  task automatic send(input int n, input logic [19:0] w);
    start();
    shift(n, w);
    finish();
  endtask

  // Abandoned write: the clock stands high past the watchdog and no stop follows.
  task automatic stall(input int n, input logic [19:0] w, input int hold_ns);
    start();
    shift(n, w);
    #(hold_ns) o_sclk = 1'b0;
    #(step) o_oe = 1'b0;
  endtask
endmodule // rsca_host

// ---- sim/rsca_rx_ctrl_bench.sv ----
`timescale 1ns/100ps

module rsca_rx_ctrl_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic demod = 1'b0;
  logic strap = 1'b1; // Straps stay high while the host programs.
  wire sclk;
  wire h_d;
  wire h_oe;
  wire pin;
  logic do_out, do_oe, den, sq, sleep;
  logic [1:0] slice, bw, dsel;
  int error_cnt = 0;
  int checks_done = 0;
  int tog = 0;
  int tcnt = 0;
  int i, k, n;

  always #10 clk = ~clk;

  // Released line shows the inverse of the last host value, so a stale level is never read.
  assign pin = do_oe ? do_out : (h_oe ? h_d : ~h_d);

  rsca_rx_ctrl #(.TIMEOUT_CYC(200), .SLEEP_BASE_CYC(100), .SQ_PERIOD_CYC(400),
    .SQ_PULSE_CYC(20)) DUT (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_SCLK(sclk), .I_DO_IN(pin), .O_DO_OUT(do_out),
    .O_DO_OE(do_oe), .I_DEMOD(demod), .I_SQUELCH_STRAP_PIN(strap), .O_SLICE_LEVEL(slice),
    .O_DEMOD_BW(bw), .O_DESENSE_EN(den), .O_DESENSE_SEL(dsel), .O_SQUELCH_ACTIVE(sq),
    .O_SLEEP(sleep));
  rsca_host HOST (.o_sclk(sclk), .o_data(h_d), .o_oe(h_oe));

  // Sliced signal: toggles every tog+1 cycles, held when tog is zero.
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    if (tog != 0 && tcnt >= tog) begin
      tcnt <= 0;
      demod <= #1 ~demod;
    end
  end

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait for the sleep flag; running out ends the run.
  task automatic wait_sleep(input logic v, input int lim);
    int j;
    for (j = 0; j < lim && sleep !== v; j++) begin
      @(posedge clk);
      #1;
    end
    chk("sleep", sleep, v);
    if (sleep !== v) summarize();
  endtask

  // Counts rising edges of the data output over a number of cycles.
  task automatic rises(input int cyc, output int cnt);
    logic prev;
    cnt = 0;
    prev = do_out;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      cnt += int'(do_out && !prev);
      prev = do_out;
    end
  endtask

  // Whole-run guard against a hang.
  initial begin
    #2000000;
    chk("timeout", 1'b1, 1'b0);
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("reset", {do_oe, do_out, sleep, slice, bw, den, dsel}, 10'h278);
    for (k = 0; k < 4; k++) begin
      HOST.step = (k == 2) ? 900 : 120;
      HOST.send(20, 20'(32'h40001 | (k << 5) | ((3 - k) << 3) | (k << 1)));
      repeat (10) @(posedge clk);
      #1 chk("cfg", {do_oe, slice, bw, den, dsel}, {1'b1, 2'(k), 2'(3 - k), 1'b1, 2'(k)});
    end
    HOST.step = 120;
    HOST.send(3, 20'h00000);
    repeat (10) @(posedge clk);
    #1 chk("partial", {slice, bw, den, dsel}, 7'h60);
    HOST.stall(5, 20'h0001F, 6000);
    repeat (10) @(posedge clk);
    #1 chk("abort", {do_oe, slice, bw, den, dsel}, 8'hE0);
    strap = 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("sq_on", sq, 1'b1);
    rises(800, n);
    chk("sq_pulses", n, 2);
    strap = 1'b1;
    repeat (6) @(posedge clk);
    #1 rises(800, n);
    chk("sq_quiet", {sq, 19'(n)}, 20'h00000);
    HOST.send(20, 20'h60078);
    repeat (10) @(posedge clk);
    #1 chk("sq_bit", sq, 1'b1);
    HOST.send(20, 20'h48EF8);
    wait_sleep(1'b1, 20);
    for (i = 0; i < 300 && sleep; i++) begin
      @(posedge clk);
      #1;
    end
    chk("sleep_len", i >= 99 && i <= 101, 1'b1);
    if (i == 300) summarize();
    tog = 50;
    wait_sleep(1'b1, 2000);
    tog = 2500;
    for (i = 0; i < 30000 && do_out !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("release", do_out, 1'b1);
    if (do_out !== 1'b1) summarize();
    tog = 0;
    demod = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("mirror", do_out, 1'b0);
    tog = 50;
    n = 0;
    repeat (3000) begin
      @(posedge clk);
      #1 n += int'(sleep);
    end
    chk("stay_awake", n, 0);
    HOST.send(0, 20'h00000);
    wait_sleep(1'b1, 20);
    summarize();
  end
endmodule // rsca_rx_ctrl_bench
